// File: design/mve_encoder.sv
// measurement value encoder: error classification, float and integer coding, apb registers
//
// How it works
// RULE1: float word is sign, 8-bit exponent, 23-bit fraction
// RULE2: byte i carries bits 8i to 8i+7
// RULE3: overflow sent as 7f 80 00 00
// RULE4: underflow sent as ff 80 00 00
// RULE5: not-a-number sent as all ones
// RULE6: pressure valid within range plus ten percent margins
// RULE7: pressure out of span sets status, sends infinity
// RULE8: faults of inputs propagate to dependent channels
// RULE9: calculated channel NaN on bad pressure input
// RULE10: pressure NaN when its temperature is infinite
// RULE11: sensor temperature +inf on overflow or above 300
// RULE12: sensor temperature -inf on underflow or below -70
// RULE13: square-root mode gives zero below cutoff pressure
// RULE14: inactive channel reads NaN, status stays clear
// RULE15: integer reads saturate NaN/+inf high, -inf low
// RULE16: analogue error level on NaN, ovl/uvl on infinities
// RULE17: host converter switches line direction by itself
// RULE18: host converter echoes each transmitted message
// RULE19: status bits 0-5 channels, 6 compute, 7 power-up
`timescale 1ns/1ps
`default_nettype none

module mve_encoder
  import mve_pkg::*;
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire mve_meas_t [NUM_CH-1:0] meas,
  input  wire logic                  powerup_flag,
  output logic      [3:0][7:0]       tx_bytes,
  output logic      [7:0]            tx_status,
  output mve_aout_t                  aout_state,
  output logic                       irq
);

  mve_state_t r;
  mve_state_t next_r;

  // integer to single precision; fraction truncated, exact up to 2^24
  function automatic logic [31:0] int_to_float(input logic signed [31:0] v);
    logic [31:0] mag;
    logic [31:0] norm;
    logic [4:0]  pos;
    logic [7:0]  expo;
    mag  = v[SIGN_BIT] ? (~v + 32'h00000001) : v;
    pos  = 5'h00;
    for (int i = 0; i < 32; i++)
    begin
      if (mag[i])
      begin
        pos = 5'(i);
      end
    end
    norm = mag << (5'h1f - pos);
    expo = EXP_BIAS + {3'h0, pos};
    if (mag == 32'h00000000)
    begin
      return FLT_ZERO;
    end
    return {v[SIGN_BIT], expo[EXP_W-1:0], norm[30 -: FRAC_W]}; // [RULE1]
  endfunction : int_to_float

  function automatic logic [31:0] encode_float(input logic [2:0] c, input logic signed [31:0] v);
    case (c)
      CLS_PINF: return FLT_PINF; // [RULE3]
      CLS_NINF: return FLT_NINF; // [RULE4]
      CLS_NAN:  return FLT_NAN;  // [RULE5]
      CLS_ZERO: return FLT_ZERO;
      default:  return int_to_float(v);
    endcase
  endfunction : encode_float

  function automatic logic [31:0] encode_int32(input logic [2:0] c, input logic signed [31:0] v);
    case (c)
      CLS_PINF, CLS_NAN: return INT32_MAX; // [RULE15]
      CLS_NINF:          return INT32_MIN; // [RULE15]
      CLS_ZERO:          return 32'h00000000;
      default:           return v;
    endcase
  endfunction : encode_int32

  // valid values beyond 16 bits saturate like the infinities
  function automatic logic [15:0] encode_int16(input logic [2:0] c, input logic signed [31:0] v);
    logic hi;
    logic lo;
    hi = (v > 32'sd32767);
    lo = (v < -32'sd32768);
    case (c)
      CLS_PINF, CLS_NAN: return INT16_MAX; // [RULE15]
      CLS_NINF:          return INT16_MIN; // [RULE15]
      CLS_ZERO:          return 16'h0000;
      default:
      begin
        if (hi)
        begin
          return INT16_MAX;
        end
        else if (lo)
        begin
          return INT16_MIN;
        end
        return v[15:0];
      end
    endcase
  endfunction : encode_int16

  function automatic logic is_bad(input logic [2:0] c);
    return (c != CLS_VALID) && (c != CLS_ZERO);
  endfunction : is_bad

  // codes 6 and 7 name no channel
  function automatic logic ch_valid(input logic [2:0] s);
    return s < 3'(NUM_CH);
  endfunction : ch_valid

  // scaled by ten so the margin needs no divider: lo = min - span/10
  function automatic logic [1:0] span_check(input logic signed [31:0] v,
                                            input logic signed [31:0] mn,
                                            input logic signed [31:0] mx);
    logic signed [35:0] v10;
    logic signed [35:0] lo10;
    logic signed [35:0] hi10;
    v10  = SPAN_DEN * 36'(v);
    lo10 = SPAN_NUM * 36'(mn) - 36'(mx);
    hi10 = SPAN_NUM * 36'(mx) - 36'(mn);
    return {v10 > hi10, v10 < lo10}; // [RULE6]
  endfunction : span_check

  function automatic logic [2:0] temp_class(input logic act, input mve_meas_t m,
                                            input logic limited);
    if (!act)
    begin
      return CLS_NAN; // [RULE14]
    end
    if (m.ovf || (limited && (m.value > TEMP_HI)))
    begin
      return CLS_PINF; // [RULE11]
    end
    if (m.unf || (limited && (m.value < TEMP_LO)))
    begin
      return CLS_NINF; // [RULE12]
    end
    return CLS_VALID;
  endfunction : temp_class

  // a bad compensating temperature outranks the span test
  function automatic logic [2:0] press_class(input logic act, input mve_meas_t m,
                                             input logic [2:0] tc,
                                             input logic signed [31:0] mn,
                                             input logic signed [31:0] mx);
    logic [1:0] out;
    out = span_check(m.value, mn, mx);
    if (!act)
    begin
      return CLS_NAN; // [RULE14]
    end
    if (is_bad(tc))
    begin
      return CLS_NAN; // [RULE10] [RULE8]
    end
    if (m.ovf || out[1])
    begin
      return CLS_PINF; // [RULE7]
    end
    if (m.unf || out[0])
    begin
      return CLS_NINF; // [RULE7]
    end
    return CLS_VALID;
  endfunction : press_class

  logic [NUM_CH-1:0][2:0] c;
  logic [NUM_CH-1:0]      err;
  logic [31:0]            rd;
  logic                   rd_ok;
  logic                   setup;
  logic                   access;
  logic [2:0]             src;
  logic signed [31:0]     calc_ref;
  logic                   sat_hi;
  logic                   sat_lo;
  logic                   sat;
  logic [7:0]             set_bits;
  logic [7:0]             clr_bits;
  logic [31:0]            sel_flt;
  logic [31:0]            sel_i32;
  logic [15:0]            sel_i16;

  always_comb
  begin
    next_r   = r;
    c        = '0;
    err      = '0;
    rd       = 32'h00000000;
    rd_ok    = 1'b1;
    src      = r.ctrl[CTRL_SRC_LO +: 3];
    calc_ref = r.ctrl[CTRL_USE_P1] ? meas[CH_P1].value : meas[CH_P2].value;
    setup    = psel && !penable;
    access   = psel && penable;

    c[CH_SENSOR_ONE_TEMPERATURE] = temp_class(r.ctrl[CH_SENSOR_ONE_TEMPERATURE], meas[CH_SENSOR_ONE_TEMPERATURE], 1'b1);
    c[CH_SENSOR_TWO_TEMPERATURE] = temp_class(r.ctrl[CH_SENSOR_TWO_TEMPERATURE], meas[CH_SENSOR_TWO_TEMPERATURE], 1'b1);
    c[CH_TEMP] = temp_class(r.ctrl[CH_TEMP], meas[CH_TEMP], 1'b0);
    c[CH_P1]   = press_class(r.ctrl[CH_P1], meas[CH_P1], c[CH_SENSOR_ONE_TEMPERATURE], r.p1_min, r.p1_max);
    c[CH_P2]   = press_class(r.ctrl[CH_P2], meas[CH_P2], c[CH_SENSOR_TWO_TEMPERATURE], r.p2_min, r.p2_max);

    if (!r.ctrl[CH_CALC])
    begin
      c[CH_CALC] = CLS_NAN; // [RULE14]
    end
    // the additional temperature channel feeds the calculation while it is active
    else if ((r.ctrl[CTRL_USE_P1] && is_bad(c[CH_P1])) ||
             (r.ctrl[CTRL_USE_P2] && is_bad(c[CH_P2])) ||
             (r.ctrl[CH_TEMP] && is_bad(c[CH_TEMP])))
    begin
      c[CH_CALC] = CLS_NAN; // [RULE9] [RULE8]
    end
    else if (r.ctrl[CTRL_SQRT] && (calc_ref < r.cutoff))
    begin
      c[CH_CALC] = CLS_ZERO; // [RULE13]
    end
    else if (meas[CH_CALC].ovf)
    begin
      c[CH_CALC] = CLS_PINF;
    end
    else if (meas[CH_CALC].unf)
    begin
      c[CH_CALC] = CLS_NINF;
    end
    else
    begin
      c[CH_CALC] = CLS_VALID;
    end

    for (int i = 0; i < NUM_CH; i++)
    begin
      err[i]        = r.ctrl[i] && is_bad(c[i]); // [RULE14] [RULE7]
      next_r.cls[i] = c[i];
      next_r.flt[i] = encode_float(c[i], meas[i].value);
      next_r.ival[i] = meas[i].value;
    end

    // the analogue source is judged on the registered copy, one sample behind
    if (ch_valid(src))
    begin
      sat_hi = (r.cls[src] == CLS_VALID) && ($signed(r.ival[src]) > r.aout_hi);
      sat_lo = (r.cls[src] == CLS_VALID) && ($signed(r.ival[src]) < r.aout_lo);
      case (r.cls[src])
        CLS_NAN:  next_r.aout = AOUT_ERROR; // [RULE16]
        CLS_PINF: next_r.aout = AOUT_OVL;   // [RULE16]
        CLS_NINF: next_r.aout = AOUT_UVL;   // [RULE16]
        default:  next_r.aout = sat_hi ? AOUT_OVL : (sat_lo ? AOUT_UVL : AOUT_NORMAL);
      endcase
    end
    else
    begin
      sat_hi      = 1'b0;
      sat_lo      = 1'b0;
      next_r.aout = AOUT_ERROR;
    end
    sat = sat_hi || sat_lo;

    // flags are set again every cycle while the fault stands
    set_bits = {powerup_flag, sat, err}; // [RULE19]
    clr_bits = 8'h00;

    if (ch_valid(r.sel))
    begin
      sel_flt = r.flt[r.sel];
      sel_i32 = encode_int32(r.cls[r.sel], r.ival[r.sel]);
      sel_i16 = encode_int16(r.cls[r.sel], r.ival[r.sel]);
    end
    else
    begin
      sel_flt = FLT_NAN;
      sel_i32 = INT32_MAX;
      sel_i16 = INT16_MAX;
    end
    next_r.tx_bytes = sel_flt; // [RULE2]

    case (paddr)
      OFS_CTRL:     rd = {20'h00000, r.ctrl};
      OFS_STATUS:   rd = {24'h000000, r.status};
      OFS_MASK:     rd = {24'h000000, r.mask};
      OFS_SEL:      rd = {29'h00000000, r.sel};
      OFS_P1_MIN:   rd = r.p1_min;
      OFS_P1_MAX:   rd = r.p1_max;
      OFS_P2_MIN:   rd = r.p2_min;
      OFS_P2_MAX:   rd = r.p2_max;
      OFS_CUTOFF:   rd = r.cutoff;
      OFS_AOUT_LO:  rd = r.aout_lo;
      OFS_AOUT_HI:  rd = r.aout_hi;
      OFS_RD_FLOAT: rd = sel_flt;
      OFS_RD_INT32: rd = sel_i32;
      OFS_RD_INT16: rd = {16'h0000, sel_i16};
      default:      rd_ok = 1'b0;
    endcase

    // read data is captured in the setup cycle so the access phase needs no wait
    if (setup)
    begin
      next_r.prdata  = pwrite ? 32'h00000000 : rd;
      next_r.pslverr = !rd_ok;
    end

    // writes to status and the result windows fall to the default and are dropped
    if (access && pwrite && rd_ok)
    begin
      case (paddr)
        OFS_CTRL:    next_r.ctrl    = pwdata[11:0];
        OFS_MASK:    next_r.mask    = pwdata[7:0];
        OFS_SEL:     next_r.sel     = pwdata[2:0];
        OFS_P1_MIN:  next_r.p1_min  = pwdata;
        OFS_P1_MAX:  next_r.p1_max  = pwdata;
        OFS_P2_MIN:  next_r.p2_min  = pwdata;
        OFS_P2_MAX:  next_r.p2_max  = pwdata;
        OFS_CUTOFF:  next_r.cutoff  = pwdata;
        OFS_AOUT_LO: next_r.aout_lo = pwdata;
        OFS_AOUT_HI: next_r.aout_hi = pwdata;
        default:     next_r.ctrl    = r.ctrl;
      endcase
    end

    if (access && !pwrite && (paddr == OFS_STATUS))
    begin
      // only bits handed out in the setup cycle are cleared; later events stay
      clr_bits = r.prdata[7:0];
    end
    // an event in the clearing cycle survives: set wins
    next_r.status = (r.status & ~clr_bits) | set_bits;
  end

  // every channel reads not-a-number until its first sample is classified
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r          <= '0;
      r.ctrl     <= CTRL_RESET;
      r.tx_bytes <= FLT_NAN;
      r.aout     <= AOUT_ERROR;
      for (int i = 0; i < NUM_CH; i++)
      begin
        r.flt[i] <= FLT_NAN;
        r.cls[i] <= CLS_NAN;
      end
    end
    else
    begin
      r <= next_r;
    end
  end

  assign prdata     = r.prdata;
  assign pslverr    = r.pslverr && psel && penable;
  // registers answer at once, so the access phase never waits
  assign pready     = 1'b1;
  assign tx_bytes   = r.tx_bytes;
  assign tx_status  = r.status;
  assign aout_state = r.aout;
  // level output: stays up until a status read or the mask drops it
  assign irq        = |(r.status & r.mask);

endmodule : mve_encoder

`default_nettype wire

// File: design/mve_pkg.sv
// package: constants, types and register map of the measurement value encoder
package mve_pkg;

  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_MASK     = 8'h08;
  localparam logic [7:0] OFS_SEL      = 8'h0c;
  localparam logic [7:0] OFS_P1_MIN   = 8'h10;
  localparam logic [7:0] OFS_P1_MAX   = 8'h14;
  localparam logic [7:0] OFS_P2_MIN   = 8'h18;
  localparam logic [7:0] OFS_P2_MAX   = 8'h1c;
  localparam logic [7:0] OFS_CUTOFF   = 8'h20;
  localparam logic [7:0] OFS_AOUT_LO  = 8'h24;
  localparam logic [7:0] OFS_AOUT_HI  = 8'h28;
  localparam logic [7:0] OFS_RD_FLOAT = 8'h2c;
  localparam logic [7:0] OFS_RD_INT32 = 8'h30;
  localparam logic [7:0] OFS_RD_INT16 = 8'h34;

  localparam int NUM_CH  = 6;
  localparam int CH_CALC = 0;
  localparam int CH_P1   = 1;
  localparam int CH_P2   = 2;
  localparam int CH_TEMP = 3;
  localparam int CH_SENSOR_ONE_TEMPERATURE = 4;
  localparam int CH_SENSOR_TWO_TEMPERATURE = 5;

  localparam int BIT_COMPUTE_ERR = 6;
  localparam int BIT_POWERUP     = 7;

  localparam int CTRL_SQRT   = 6;
  localparam int CTRL_USE_P1 = 7;
  localparam int CTRL_USE_P2 = 8;
  localparam int CTRL_SRC_LO = 9;
  localparam logic [11:0] CTRL_RESET = 12'h092;

  localparam int SIGN_BIT  = 31;
  localparam int EXP_W     = 8;
  localparam int FRAC_W    = 23;
  localparam logic [7:0] EXP_BIAS = 8'h7f;

  localparam logic [31:0] FLT_ZERO = 32'h00000000;
  localparam logic [31:0] FLT_PINF = 32'h7f800000;
  localparam logic [31:0] FLT_NINF = 32'hff800000;
  localparam logic [31:0] FLT_NAN  = 32'hffffffff;
  localparam logic [31:0] INT32_MAX = 32'h7fffffff;
  localparam logic [31:0] INT32_MIN = 32'h80000000;
  localparam logic [15:0] INT16_MAX = 16'h7fff;
  localparam logic [15:0] INT16_MIN = 16'h8000;

  // temperatures in 0.01 degC: 300 degC and -70 degC
  localparam logic signed [31:0] TEMP_HI = 32'sd30000;
  localparam logic signed [31:0] TEMP_LO = -32'sd7000;
  // span margin as a fraction: tenths
  localparam logic signed [35:0] SPAN_DEN = 36'sd10;
  localparam logic signed [35:0] SPAN_NUM = 36'sd11;

  typedef enum logic [2:0] {
    CLS_VALID = 3'b000,
    CLS_PINF  = 3'b001,
    CLS_NINF  = 3'b010,
    CLS_NAN   = 3'b011,
    CLS_ZERO  = 3'b100
  } mve_cls_t;

  typedef enum logic [1:0] {
    AOUT_NORMAL = 2'b00,
    AOUT_ERROR  = 2'b01,
    AOUT_OVL    = 2'b10,
    AOUT_UVL    = 2'b11
  } mve_aout_t;

  typedef struct packed {
    logic signed [31:0] value;
    logic               ovf;
    logic               unf;
  } mve_meas_t;

  typedef struct packed {
    logic [11:0]                ctrl;
    logic [7:0]                 status;
    logic [7:0]                 mask;
    logic [2:0]                 sel;
    logic signed [31:0]         p1_min;
    logic signed [31:0]         p1_max;
    logic signed [31:0]         p2_min;
    logic signed [31:0]         p2_max;
    logic signed [31:0]         cutoff;
    logic signed [31:0]         aout_lo;
    logic signed [31:0]         aout_hi;
    logic [NUM_CH-1:0][31:0]    flt;
    logic [NUM_CH-1:0][2:0]     cls;
    logic [NUM_CH-1:0][31:0]    ival;
    logic [31:0]                prdata;
    logic                       pslverr;
    logic [3:0][7:0]            tx_bytes;
    mve_aout_t                  aout;
  } mve_state_t;

endpackage : mve_pkg

// File: verification/mve_encoder_properties.sv
// checker: port-level properties of the value encoder
`timescale 1ns/1ps
`default_nettype none
module mve_encoder_properties
  import mve_pkg::*;
(
  input wire logic            pclk,
  input wire logic            presetn,
  input wire logic            psel,
  input wire logic            penable,
  input wire logic            pwrite,
  input wire logic [7:0]      paddr,
  input wire logic [31:0]     prdata,
  input wire logic            pready,
  input wire logic            pslverr,
  input wire logic            powerup_flag,
  input wire logic [3:0][7:0] tx_bytes,
  input wire logic [7:0]      tx_status,
  input wire logic            irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic st_rd;
  assign st_rd = psel && penable && !pwrite && paddr == OFS_STATUS;

  chk_ready_high: assert property (pready)
    else $error("pready low");
  chk_err_phase: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access");
  chk_err_data: assert property (pslverr |-> prdata == 32'h00000000)
    else $error("error read not zero");
  chk_read_hold: assert property (psel && penable && pready |=> $stable(prdata))
    else $error("read data moved");
  chk_exp_special: assert property ((tx_bytes[3][6:0] == 7'h7f && tx_bytes[2][7]) |->
    (tx_bytes == FLT_PINF || tx_bytes == FLT_NINF || tx_bytes == FLT_NAN))
    else $error("bad special float");
  chk_inf_bytes: assert property ((tx_bytes[2] == 8'h80 && tx_bytes[3][6:0] == 7'h7f) |->
    tx_bytes[1] == 8'h00 && tx_bytes[0] == 8'h00)
    else $error("infinity low bytes");
  chk_powerup_bit: assert property (powerup_flag |=> tx_status[BIT_POWERUP])
    else $error("power-up bit missing");
  // status only falls through a read, so no event is lost
  chk_status_sticky: assert property ((($past(tx_status) & ~tx_status) != 8'h00) |->
    $past(st_rd))
    else $error("status fell unread");
  chk_irq_cause: assert property (irq |-> tx_status != 8'h00)
    else $error("irq with empty status");

  cov_err: cover property (pslverr);
  cov_irq: cover property ($rose(irq));
  cov_ninf: cover property (tx_bytes == FLT_NINF);
endmodule : mve_encoder_properties

bind mve_encoder mve_encoder_properties u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .powerup_flag(powerup_flag), .tx_bytes(tx_bytes),
  .tx_status(tx_status), .irq(irq));
`default_nettype wire

// File: verification/mve_host_model.sv
// host model: reassembles the sent float and echoes it back
`timescale 1ns/1ps
`default_nettype none
module mve_host_model
(
  input  wire logic            pclk,
  input  wire logic [3:0][7:0] tx_bytes,
  output logic      [31:0]     rx_word,
  output logic      [31:0]     rx_echo
);
  // line turns round without host control, so capture runs every clock
  always_ff @(posedge pclk)
  begin
    rx_word <= {tx_bytes[3], tx_bytes[2], tx_bytes[1], tx_bytes[0]};
    rx_echo <= rx_word;
  end
endmodule : mve_host_model
`default_nettype wire

// File: verification/tb_measurement_value_error_encoder.sv
// testbench: apb and measurement stimulus against a reference model
`timescale 1ns/1ps
`default_nettype none
module tb_measurement_value_error_encoder
  import mve_pkg::*;
;
  logic                   pclk = 0, presetn = 0, psel = 0, penable = 0;
  logic                   pwrite = 0, powerup_flag = 0, pready, pslverr, irq, lerr;
  logic [7:0]             paddr = 0, tx_status;
  logic [31:0]            pwdata = 0, prdata, rd, rx_word, rx_echo;
  logic [3:0][7:0]        tx_bytes;
  mve_aout_t              aout_state;
  mve_meas_t [NUM_CH-1:0] meas = '0;
  int                     n_fail = 0, n_compared = 0, pmn = 0, pmx = 1000;

  always #10 pclk = ~pclk;

  mve_encoder u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .meas(meas), .powerup_flag(powerup_flag), .tx_bytes(tx_bytes),
    .tx_status(tx_status), .aout_state(aout_state), .irq(irq));
  mve_host_model u_host (.pclk(pclk), .tx_bytes(tx_bytes), .rx_word(rx_word),
    .rx_echo(rx_echo));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic stop_test();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : stop_test

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    rd = prdata;
    lerr = pslverr;
    psel <= 0;
    penable <= 0;
    if (k >= 20)
    begin
      n_fail++;
      stop_test();
    end
  endtask : apb

  function automatic logic [31:0] i2f(input int v);
    int a;
    int e;
    if (v == 0)
      return FLT_ZERO;
    a = v < 0 ? -v : v;
    e = 30;
    while (!a[e])
      e--;
    return {v < 0, 8'(127 + e), 23'(e > 23 ? a >> (e - 23) : a << (23 - e))};
  endfunction : i2f

  function automatic logic [31:0] p1_model(input int v, input logic o, input logic u, input int t);
    if (t > 30000 || t < -7000)
      return FLT_NAN;
    if (o || 10 * v > 11 * pmx - pmn)
      return FLT_PINF;
    if (u || 10 * v < 11 * pmn - pmx)
      return FLT_NINF;
    return i2f(v);
  endfunction : p1_model

  function automatic logic [31:0] i_model(input logic [31:0] w, input int v, input bit h);
    if (w == FLT_NINF)
      return h ? 32'(INT16_MIN) : INT32_MIN;
    if (w == FLT_NAN || w == FLT_PINF)
      return h ? 32'(INT16_MAX) : INT32_MAX;
    return h ? {16'h0000, v[15:0]} : v;
  endfunction : i_model

  task automatic run_p1(input int v, input logic o, input logic u, input int t);
    logic [31:0] w;
    logic        bad;
    logic        tb;
    w = p1_model(v, o, u, t);
    bad = w == FLT_NAN || w == FLT_PINF || w == FLT_NINF;
    tb = t > 30000 || t < -7000;
    @(posedge pclk);
    meas[CH_P1] <= '{v, o, u};
    meas[CH_SENSOR_ONE_TEMPERATURE] <= '{t, 1'b0, 1'b0};
    repeat (5) @(posedge pclk);
    chk("tx_bytes", rx_word, w);
    chk("echo", rx_echo, w);
    chk("aout", aout_state, w == FLT_NAN ? AOUT_ERROR : w == FLT_PINF ? AOUT_OVL :
      w == FLT_NINF ? AOUT_UVL : AOUT_NORMAL);
    apb(0, OFS_RD_FLOAT, 0);
    chk("float", rd, w);
    apb(0, OFS_RD_INT32, 0);
    chk("int32", rd, i_model(w, v, 0));
    apb(0, OFS_RD_INT16, 0);
    chk("int16", rd, i_model(w, v, 1));
    // first read drops stale bits, second shows the live condition
    apb(0, OFS_STATUS, 0);
    apb(0, OFS_STATUS, 0);
    chk("status", rd, {27'h0, tb, 2'b00, bad, bad});
  endtask : run_p1

  initial
  begin
    int q[$];
    void'($urandom(95));
    repeat (2) @(posedge pclk);
    chk("rst_tx", tx_bytes, FLT_NAN);
    chk("rst_aout", aout_state, AOUT_ERROR);
    presetn <= 1;
    apb(0, OFS_CTRL, 0);
    chk("rst_ctrl", rd, 32'(CTRL_RESET));
    apb(1, OFS_P1_MAX, 32'h000003e8);
    apb(1, OFS_AOUT_HI, 32'h000186a0);
    apb(1, OFS_AOUT_LO, 32'hfffe7960);
    apb(1, OFS_CTRL, 32'h00000293);
    apb(1, OFS_SEL, 32'(CH_P1));
    q = '{500, 1100, 1101, -100, -101, 0};
    repeat (4) q.push_back(int'($urandom_range(1300, 0)) - 150);
    foreach (q[i])
      run_p1(q[i], 0, 0, 2500);
    run_p1(300, 0, 1, 2500);
    run_p1(300, 0, 0, 30000);
    run_p1(300, 0, 0, 30001);
    run_p1(300, 0, 0, -7001);
    apb(1, OFS_MASK, 32'h00000002);
    run_p1(300, 1, 0, 2500);
    @(posedge pclk);
    chk("irq_on", irq, 1'b1);
    apb(1, OFS_MASK, 32'h00000000);
    @(posedge pclk);
    chk("irq_masked", irq, 1'b0);
    apb(1, OFS_MASK, 32'h00000002);
    run_p1(300, 0, 0, 2500);
    @(posedge pclk);
    chk("irq_off", irq, 1'b0);
    powerup_flag <= 1;
    @(posedge pclk);
    powerup_flag <= 0;
    apb(0, OFS_STATUS, 0);
    chk("powerup", rd[BIT_POWERUP], 1'b1);
    apb(1, OFS_SEL, 32'h00000002);
    apb(0, OFS_RD_FLOAT, 0);
    chk("inactive", rd, FLT_NAN);
    apb(0, OFS_STATUS, 0);
    apb(0, OFS_STATUS, 0);
    chk("inactive_st", rd[CH_P2], 1'b0);
    apb(0, 8'hfc, 0);
    chk("unmapped_err", lerr, 1'b1);
    chk("unmapped_rd", rd, 32'h00000000);
    apb(1, OFS_SEL, 32'h00000000);
    apb(1, OFS_CUTOFF, 32'h00000258);
    meas[CH_CALC] <= '{1234, 1'b0, 1'b0};
    meas[CH_P1] <= '{500, 1'b0, 1'b0};
    apb(1, OFS_CTRL, 32'h000002d3);
    apb(0, OFS_RD_FLOAT, 0);
    chk("sqrt_low", rd, FLT_ZERO);
    meas[CH_P1] <= '{700, 1'b0, 1'b0};
    repeat (3) @(posedge pclk);
    apb(0, OFS_RD_FLOAT, 0);
    chk("sqrt_high", rd, i2f(1234));
    // scale top below the valid source value drives the output into saturation
    apb(1, OFS_AOUT_HI, 32'h000001f4);
    repeat (2) @(posedge pclk);
    chk("aout_sat", aout_state, AOUT_OVL);
    apb(0, OFS_STATUS, 0);
    chk("compute_err", rd[BIT_COMPUTE_ERR], 1'b1);
    stop_test();
  end
endmodule : tb_measurement_value_error_encoder
`default_nettype wire
